// ==== bench/pocr_power_stage.sv ====
// power stage model: stream sink with stall
`timescale 1ns/10ps
`default_nettype none
module pocr_power_stage (
    input  wire logic                        clk,
    input  wire logic                        stall,
    input  wire logic                        m_valid,
    input  wire logic [pocr_pkg::DATA_W-1:0] m_data,
    output logic                             m_ready
);
    logic [pocr_pkg::DATA_W-1:0] got [$];
    assign m_ready = !stall;
    always @(posedge clk) if (m_valid && m_ready) got.push_back(m_data);
endmodule
`default_nettype wire

// ==== bench/pocr_router_properties.sv ====
// checker: port properties of the pwm router
`timescale 1ns/10ps
`default_nettype none
module pocr_router_properties (
    input wire logic                        CLK_SYS,
    input wire logic                        RSTN,
    input wire logic [7:0]                  PADDR,
    input wire logic                        PSEL,
    input wire logic                        PENABLE,
    input wire logic                        PWRITE,
    input wire logic [31:0]                 PWDATA,
    input wire logic [31:0]                 PRDATA,
    input wire logic                        PREADY,
    input wire logic                        PSLVERR,
    input wire logic                        M_VALID,
    input wire logic                        M_READY,
    input wire logic [pocr_pkg::DATA_W-1:0] M_DATA,
    input wire logic [3:0]                  BINARY_MODE,
    input wire logic                        LINE_VOL_EN,
    input wire logic                        LINE_EQ_EN,
    input wire logic                        CH3_FULL_PROC,
    input wire logic                        PARALLEL_BRIDGE_EN
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    wire         acc = PSEL && PENABLE;
    logic [1:0]  oc_reg;
    // shadow of the written output configuration
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) oc_reg <= 2'h0;
        else if (acc && PWRITE && PADDR == 8'h00) oc_reg <= PWDATA[1:0];
    end
    a_apb_zero_wait: assert property (acc |-> PREADY)
        else $error("no ready");
    a_unmapped_err: assert property (acc && PADDR > 8'h08 |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped not refused");
    a_mapped_ok: assert property (acc && PADDR[1:0] == 2'h0 && PADDR <= 8'h08 |-> !PSLVERR)
        else $error("mapped refused");
    a_bridge_mono: assert property ($stable(oc_reg)[*3] |-> PARALLEL_BRIDGE_EN == (oc_reg == 2'h3))
        else $error("bridge wrong");
    a_ch3_full: assert property ($stable(oc_reg)[*3] |-> CH3_FULL_PROC == (oc_reg != 2'h0))
        else $error("ch3 proc wrong");
    a_line_direct_only: assert property ($stable(oc_reg)[*3] ##0 oc_reg != 2'h0 |-> !LINE_VOL_EN && !LINE_EQ_EN)
        else $error("line out active");
    a_half_binary: assert property ($stable(oc_reg)[*3] ##0 oc_reg == 2'h1 |-> BINARY_MODE == 4'h7)
        else $error("half not binary");
    a_mono_ch3_bin: assert property ($stable(oc_reg)[*3] ##0 oc_reg == 2'h3 |-> BINARY_MODE[2])
        else $error("mono ch3 not binary");
    a_stream_hold: assert property (M_VALID && !M_READY |=> M_VALID && $stable(M_DATA))
        else $error("stalled word lost");
    c_mono: cover property (oc_reg == 2'h3 && PARALLEL_BRIDGE_EN);
    c_refused: cover property (acc && PSLVERR);
    c_stall: cover property (M_VALID && !M_READY);
endmodule
bind pocr_router pocr_router_properties u_props (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .M_VALID(M_VALID), .M_READY(M_READY), .M_DATA(M_DATA),
    .BINARY_MODE(BINARY_MODE), .LINE_VOL_EN(LINE_VOL_EN),
    .LINE_EQ_EN(LINE_EQ_EN), .CH3_FULL_PROC(CH3_FULL_PROC),
    .PARALLEL_BRIDGE_EN(PARALLEL_BRIDGE_EN));
`default_nettype wire

// ==== bench/pocr_router_test.sv ====
// bench for the pwm output router
`timescale 1ns/10ps
`default_nettype none
module pocr_router_test;
    logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, er;
    logic        mclk = 0, mclk_run = 1, lrclk = 0, tw = 0, amp = 0;
    logic        s_valid = 0, m_valid, m_ready, stall = 0, lc, lv, le;
    logic        ch3, pbe, seen0, seen1;
    logic [7:0]  paddr = 0, mod = 0, pwm;
    logic [31:0] pwdata = 0, prdata, r;
    logic [23:0] m_data, e [$];
    logic [3:0]  bin;
    logic        pready, pslverr, s_ready, mute;
    pocr_pkg::pocr_sample_t s_data = '0;
    int          errors = 0, n_compared = 0, k;
    logic [11:0] chv [5] = '{12'h900, 12'h901, 12'h902, 12'h903, 12'h9c0};
    logic [7:0]  pv [5] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'hfc};
    always #50 clk = ~clk;
    always @(posedge clk) mclk <= mclk_run ? ~mclk : mclk;
    pocr_router dut (.CLK_SYS(clk), .RSTN(rstn), .PADDR(paddr), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MOD_PWM(mod), .MCLK_IN(mclk),
        .LRCLK_IN(lrclk), .THERMAL_WARNING(tw), .EXT_AMP_POWERDOWN(amp),
        .S_VALID(s_valid), .S_READY(s_ready), .S_DATA(s_data),
        .M_VALID(m_valid), .M_READY(m_ready), .M_DATA(m_data), .PWM_OUT(pwm),
        .LRCLK_CLEAN(lc), .BINARY_MODE(bin), .LINE_VOL_EN(lv),
        .LINE_EQ_EN(le), .CH3_FULL_PROC(ch3), .PARALLEL_BRIDGE_EN(pbe),
        .AUTO_MUTE(mute));
    pocr_power_stage ps (.clk(clk), .stall(stall), .m_valid(m_valid),
        .m_data(m_data), .m_ready(m_ready));
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            errors++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin errors++; final_report(); end
        r = prdata; er = pslverr;
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    task push(input logic [24:0] d);
        s_data <= d; s_valid <= 1;
        k = 0;
        do begin @(posedge clk); k++; end while (s_ready !== 1'b1 && k < 200);
        if (k >= 200) begin errors++; final_report(); end
    endtask
    function automatic logic [7:0] emap(input logic [1:0] c,
                                        input logic [7:0] m, input logic a, t);
        case (c)
            2'h0: emap = m;
            2'h1: emap = {m[3:0], m[5], m[4], m[2], m[0]};
            2'h2: emap = {t, a, m[5:0]};
            default: emap = {m[3:0], m[5], m[5], m[4], m[4]};
        endcase
    endfunction
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1;
        repeat (4) @(posedge clk);
        apb(0, 8'h00, 0); chk("cfg", r, 32'h1c);
        apb(0, 8'h04, 0); chk("chan", r, 32'h900);
        apb(0, 8'h0c, 0); chk("err", {r[30:0], er}, 32'h1);
        $display("registers done");
        for (int c = 0; c < 4; c++) begin
            for (int p = 0; p < 2; p++) begin
                apb(1, 8'h00, 32'h1c | c);
                mod <= p ? 8'h5a : 8'ha5; amp <= !p; tw <= p;
                repeat (110) @(posedge clk);
                chk("map", pwm, emap(c, p ? 8'h5a : 8'ha5, !p, p));
                chk("bin", bin, c == 1 ? 4'h7 : (c == 3 ? 4'h4 : 4'h0));
                chk("mode", {pbe, ch3}, {c == 3, c != 0});
            end
        end
        $display("mappings done");
        apb(1, 8'h00, 32'h1c);
        mod <= 8'hff;
        for (int i = 0; i < 5; i++) begin
            apb(1, 8'h04, chv[i]);
            repeat (110) @(posedge clk);
            chk("line", {lv, le}, {i == 1 || i == 2, i == 2});
            chk("silent", pwm, pv[i]);
        end
        $display("line out done");
        stall <= 1;
        s_valid <= 1;
        k = 0;
        repeat (40) begin
            @(posedge clk);
            if (s_ready) begin k++; s_data <= 25'(k); end
        end
        chk("full", {s_ready, k >= 16}, 2'b01);
        for (int i = 0; i <= k; i++) e.push_back(24'(i));
        repeat (5) e.push_back(0);
        e.push_back(24'h10005);
        stall <= 0;
        push(25'(k));
        push(25'h1000bad);
        for (int i = 1; i < 6; i++) push(25'h10000 + 25'(i));
        s_valid <= 0;
        repeat (30) @(posedge clk);
        chk("count", ps.got.size(), e.size());
        foreach (e[i]) chk("word", ps.got[i], e[i]);
        chk("mute", mute, 0);
        $display("stream done");
        mclk_run <= 0; mod <= 8'h00;
        apb(1, 8'h00, 32'h1d);
        repeat (60) @(posedge clk);
        apb(0, 8'h08, 0); chk("lost", r[1], 1);
        seen0 = 0; seen1 = 0;
        repeat (110) begin
            @(posedge clk);
            seen0 |= !pwm[0]; seen1 |= pwm[0];
        end
        chk("square", {seen0, seen1}, 2'b11);
        apb(1, 8'h00, 32'h15);
        repeat (110) @(posedge clk);
        chk("static", pwm, 8'h00);
        lrclk <= 1;
        repeat (5) @(posedge clk);
        lrclk <= 0;
        repeat (60) @(posedge clk);
        apb(0, 8'h08, 0); chk("guard", {r[23:16], r[2]}, 9'h3);
        chk("clean", lc, 1);
        $display("protection done");
        final_report();
    end
endmodule
`default_nettype wire

// ==== shared/pocr_pkg.sv ====
// package: register map, field layout, timing and types of the pwm output router
package pocr_pkg;
    localparam int DATA_W = 24;
    localparam int FIFO_DEPTH = 16;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_CHAN = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_MUTE_BIT = 2;
    localparam int CFG_LOSS_BIT = 3;
    localparam int CFG_GRD_BIT = 4;
    localparam logic [4:0] CFG_RESET = 5'h1c;
    localparam int CHAN_LN_LSB = 0;
    localparam int CHAN_BIN_LSB = 2;
    localparam int CHAN_MAP_LSB = 6;
    localparam logic [11:0] CHAN_RESET = 12'h900;
    localparam int STAT_LEVEL_LSB = 8;
    localparam int STAT_SUPP_LSB = 16;
    localparam logic [1:0] OC_DIRECT = 2'h0;
    localparam logic [1:0] OC_HALF = 2'h1;
    localparam logic [1:0] OC_EXT = 2'h2;
    localparam logic [1:0] OC_MONO = 2'h3;
    localparam logic [1:0] LN_VOL = 2'h1;
    localparam logic [1:0] LN_VOL_EQ = 2'h2;
    localparam logic [1:0] LN_RSVD = 2'h3;
    localparam int CLK_HZ = 10_000_000;
    localparam int FS_HZ = 96_000;
    localparam int SLOTS = 8;
    localparam int SLOT_CYCLES = CLK_HZ / (SLOTS * FS_HZ);
    localparam int LOSS_NS = 2000;
    localparam int LOSS_CYCLES = (LOSS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int GUARD_NS = 5000;
    localparam int GUARD_CYCLES = (GUARD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int VALID_RUN = 4;
    localparam logic [2:0] PAIR_SLOT [4] = '{3'h0, 3'h2, 3'h1, 3'h2};
    typedef enum logic [1:0] {SRC_PWM, SRC_ZERO, SRC_AMP, SRC_WARN} pocr_src_t;
    typedef enum logic {MS_PLAY, MS_MUTED} pocr_mute_t;
    typedef struct packed {
        logic              bad;
        logic [DATA_W-1:0] pcm;
    } pocr_sample_t;
endpackage

// ==== verilog/pocr_router.sv ====
// pwm output router: fifo, register slave and output mapping logic
// Function
// - two-bit output configuration field, bits 0 and 1, reset 0, picks mapping
// - config 00 routes each mapped channel straight through, pairs 3/4 driven low under the reserved line setting
// - config 00: per-channel binary or ternary, pairs 3/4 line out
// - line setting 00: pair 3 carries the channel mapped to it (reset 3), pair 4 channel 4
// - fixed line setting: no volume or equalisation on pairs 3 and 4
// - config 01: 1A, 2A, 3A/3B, 1A/1B, 2A/2B feed outputs
// - config 01: channels 1-3 binary at 0, 90, 45 degrees
// - config 01: channel 3 fully processed, pairs 3/4 replicate 1/2
// - config 10: pairs 1-3 direct, amp powerdown on 4A, warning on 4B
// - config 10: per-channel binary selection, channel 3 fully processed
// - config 11: mono parallel mapping, bridging enabled only here
// - each channel's edges stay in its slot of one eighth sample, except under the clock-loss 50% output, which switches at slots 0 and 4
// - any processing channel may be mapped to any of three inputs; only pairs 1-3 have a map field, pair 4 is fixed to channel 4
// - invalid input mute enable, bit 2 reset 1, mutes on invalid data
// - clock loss enable, bit 3 reset 1, binary outputs go to 50% duty
// - frame clock guard enable, bit 4 reset 1, suppresses double triggers
// - line setting acts only in 00: fixed, volume, volume with eq, reserved
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

module pocr_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic [WIDTH-1:0]   in_data,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output logic [WIDTH-1:0]        out_data,
    output logic [$clog2(DEPTH):0]  level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_reg];
    assign level = count_reg;

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            in_ready   <= 1'b0;
            out_valid  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready  <= (count_next != (AW + 1)'(DEPTH));
            out_valid <= (count_next != '0);
        end
    end
endmodule

module pocr_router (
    input  wire logic                   CLK_SYS,
    input  wire logic                   RSTN,
    input  wire logic [7:0]             PADDR,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [31:0]            PWDATA,
    output logic [31:0]                 PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    input  wire logic [7:0]             MOD_PWM,
    input  wire logic                   MCLK_IN,
    input  wire logic                   LRCLK_IN,
    input  wire logic                   THERMAL_WARNING,
    input  wire logic                   EXT_AMP_POWERDOWN,
    input  wire logic                   S_VALID,
    output logic                        S_READY,
    input  wire pocr_pkg::pocr_sample_t S_DATA,
    output logic                        M_VALID,
    input  wire logic                   M_READY,
    output logic [pocr_pkg::DATA_W-1:0] M_DATA,
    output logic [7:0]                  PWM_OUT,
    output logic                        LRCLK_CLEAN,
    output logic [3:0]                  BINARY_MODE,
    output logic                        LINE_VOL_EN,
    output logic                        LINE_EQ_EN,
    output logic                        CH3_FULL_PROC,
    output logic                        PARALLEL_BRIDGE_EN,
    output logic                        AUTO_MUTE
);
    localparam int FW = $bits(pocr_pkg::pocr_sample_t);
    localparam int LW = $clog2(pocr_pkg::FIFO_DEPTH) + 1;

    logic [1:0]            rst_sync_reg;
    logic                  rst_n;
    logic [2:0]            pin_s1_reg;
    logic [2:0]            pin_s2_reg;
    logic                  mclk_d_reg;
    logic                  lr_d_reg;
    logic [4:0]            cfg_reg;
    logic [11:0]           chan_reg;
    logic [1:0]            output_config_sel;
    logic                  invalid_input_mute_en;
    logic                  clock_loss_detect_en;
    logic                  frame_clock_retrigger_guard_en;
    logic [1:0]            line_output_sel;
    logic [3:0]            ch_binary_mode_sel;
    logic [7:0]            loss_cnt_reg;
    logic                  clk_lost_reg;
    logic [7:0]            guard_cnt_reg;
    logic [7:0]            supp_cnt_reg;
    logic                  lr_edge;
    logic                  lr_accept;
    logic                  frame_start;
    logic [7:0]            slot_cnt_reg;
    logic [2:0]            slot_idx_reg;
    logic [7:0]            m_vec;
    logic [3:0]            bin_eff;
    logic [2:0]            src_m [8];
    pocr_pkg::pocr_src_t   src_k [8];
    logic [7:0]            pwm_next;
    logic                  f_valid;
    logic                  f_ready;
    logic [FW-1:0]         f_data;
    pocr_pkg::pocr_sample_t f_word;
    logic [LW-1:0]         f_level;
    logic                  pop;
    pocr_pkg::pocr_mute_t  mute_state_reg;
    logic [2:0]            run_cnt_reg;
    logic                  drop_word;
    logic                  wr_en;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
            mclk_d_reg <= 1'b0;
            lr_d_reg   <= 1'b0;
        end else begin
            pin_s1_reg <= {THERMAL_WARNING, LRCLK_IN, MCLK_IN};
            pin_s2_reg <= pin_s1_reg;
            mclk_d_reg <= pin_s2_reg[0];
            lr_d_reg   <= pin_s2_reg[1];
        end
    end

    assign output_config_sel = cfg_reg[pocr_pkg::CFG_SEL_LSB +: 2];
    assign invalid_input_mute_en = cfg_reg[pocr_pkg::CFG_MUTE_BIT];
    assign clock_loss_detect_en = cfg_reg[pocr_pkg::CFG_LOSS_BIT];
    assign frame_clock_retrigger_guard_en = cfg_reg[pocr_pkg::CFG_GRD_BIT];
    assign line_output_sel = chan_reg[pocr_pkg::CHAN_LN_LSB +: 2];
    assign ch_binary_mode_sel = chan_reg[pocr_pkg::CHAN_BIN_LSB +: 4];
    assign wr_en = PSEL & PENABLE & PWRITE;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg  <= pocr_pkg::CFG_RESET;
            chan_reg <= pocr_pkg::CHAN_RESET;
        end else if (wr_en) begin
            if (hit(PADDR, pocr_pkg::OFS_CFG)) begin
                cfg_reg <= PWDATA[4:0];
            end
            if (hit(PADDR, pocr_pkg::OFS_CHAN)) begin
                chan_reg <= PWDATA[11:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA  <= 32'h0;
            PSLVERR <= 1'b0;
            PREADY  <= 1'b0;
        end else begin
            PREADY <= 1'b1;
            if (PSEL && !PENABLE) begin
                PSLVERR <= 1'b0;
                PRDATA  <= 32'h0;
                if (hit(PADDR, pocr_pkg::OFS_CFG)) begin
                    PRDATA[4:0] <= cfg_reg;
                end else if (hit(PADDR, pocr_pkg::OFS_CHAN)) begin
                    PRDATA[11:0] <= chan_reg;
                end else if (hit(PADDR, pocr_pkg::OFS_STAT)) begin
                    PRDATA[0] <= (mute_state_reg == pocr_pkg::MS_MUTED);
                    PRDATA[1] <= clk_lost_reg;
                    PRDATA[2] <= LRCLK_CLEAN;
                    PRDATA[pocr_pkg::STAT_LEVEL_LSB +: LW] <= f_level;
                    PRDATA[pocr_pkg::STAT_SUPP_LSB +: 8] <= supp_cnt_reg;
                end else begin
                    PSLVERR <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            loss_cnt_reg <= 8'h0;
            clk_lost_reg <= 1'b0;
        end else begin
            if (pin_s2_reg[0] != mclk_d_reg) begin
                loss_cnt_reg <= 8'h0;
            end else if (loss_cnt_reg != 8'(pocr_pkg::LOSS_CYCLES)) begin
                loss_cnt_reg <= loss_cnt_reg + 8'h1;
            end
            clk_lost_reg <= (loss_cnt_reg == 8'(pocr_pkg::LOSS_CYCLES));
        end
    end

    assign lr_edge = (pin_s2_reg[1] != lr_d_reg);
    assign lr_accept = lr_edge & (!frame_clock_retrigger_guard_en
                     | (guard_cnt_reg == 8'(pocr_pkg::GUARD_CYCLES)));
    assign frame_start = lr_accept & pin_s2_reg[1];

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            guard_cnt_reg <= 8'h0;
            supp_cnt_reg  <= 8'h0;
            LRCLK_CLEAN   <= 1'b0;
        end else begin
            if (lr_accept) begin
                guard_cnt_reg <= 8'h0;
                LRCLK_CLEAN   <= pin_s2_reg[1];
            end else if (guard_cnt_reg != 8'(pocr_pkg::GUARD_CYCLES)) begin
                guard_cnt_reg <= guard_cnt_reg + 8'h1;
            end
            if (lr_edge && !lr_accept && supp_cnt_reg != 8'hff) begin
                supp_cnt_reg <= supp_cnt_reg + 8'h1;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            slot_cnt_reg <= 8'h0;
            slot_idx_reg <= 3'h0;
        end else if (frame_start) begin
            slot_cnt_reg <= 8'h0;
            slot_idx_reg <= 3'h0;
        end else if (slot_cnt_reg == 8'(pocr_pkg::SLOT_CYCLES - 1)) begin
            slot_cnt_reg <= 8'h0;
            slot_idx_reg <= slot_idx_reg + 3'h1;
        end else begin
            slot_cnt_reg <= slot_cnt_reg + 8'h1;
        end
    end

    always_comb begin
        m_vec = 8'h0;
        for (int p = 0; p < 3; p++) begin
            case (chan_reg[pocr_pkg::CHAN_MAP_LSB + 2 * p +: 2])
                2'h0: m_vec[2 * p +: 2] = MOD_PWM[1:0];
                2'h1: m_vec[2 * p +: 2] = MOD_PWM[3:2];
                2'h2: m_vec[2 * p +: 2] = MOD_PWM[5:4];
                default: m_vec[2 * p +: 2] = 2'h0;
            endcase
        end
        m_vec[7:6] = MOD_PWM[7:6];
    end

    always_comb begin
        bin_eff = ch_binary_mode_sel;
        case (output_config_sel)
            pocr_pkg::OC_HALF: bin_eff = 4'h7;
            pocr_pkg::OC_MONO: bin_eff[2] = 1'b1;
            default: ;
        endcase
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            src_k[i] = pocr_pkg::SRC_PWM;
            src_m[i] = 3'(i);
        end
        case (output_config_sel)
            pocr_pkg::OC_DIRECT: begin
                if (line_output_sel == pocr_pkg::LN_RSVD) begin
                    for (int i = 4; i < 8; i++) begin
                        src_k[i] = pocr_pkg::SRC_ZERO;
                    end
                end
            end
            pocr_pkg::OC_HALF: begin
                src_m[1] = 3'h2;
                src_m[2] = 3'h4;
                src_m[3] = 3'h5;
                src_m[4] = 3'h0;
                src_m[5] = 3'h1;
                src_m[6] = 3'h2;
                src_m[7] = 3'h3;
            end
            pocr_pkg::OC_EXT: begin
                src_k[6] = pocr_pkg::SRC_AMP;
                src_k[7] = pocr_pkg::SRC_WARN;
            end
            default: begin
                src_m[0] = 3'h4;
                src_m[1] = 3'h4;
                src_m[2] = 3'h5;
                src_m[3] = 3'h5;
                src_m[4] = 3'h0;
                src_m[5] = 3'h1;
                src_m[6] = 3'h2;
                src_m[7] = 3'h3;
            end
        endcase
    end

    for (genvar g = 0; g < 8; g++) begin : g_out
        always_comb begin
            pwm_next[g] = PWM_OUT[g];
            case (src_k[g])
                pocr_pkg::SRC_ZERO: pwm_next[g] = 1'b0;
                pocr_pkg::SRC_AMP: pwm_next[g] = EXT_AMP_POWERDOWN;
                pocr_pkg::SRC_WARN: pwm_next[g] = pin_s2_reg[2];
                default: begin
                    if (clock_loss_detect_en && clk_lost_reg
                        && bin_eff[src_m[g][2:1]]) begin
                        pwm_next[g] = slot_idx_reg[2] ^ src_m[g][0];
                    end else if (slot_idx_reg
                                 == pocr_pkg::PAIR_SLOT[src_m[g][2:1]]) begin
                        pwm_next[g] = m_vec[src_m[g]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            PWM_OUT <= 8'h0;
        end else begin
            PWM_OUT <= pwm_next;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            BINARY_MODE        <= 4'h0;
            LINE_VOL_EN        <= 1'b0;
            LINE_EQ_EN         <= 1'b0;
            CH3_FULL_PROC      <= 1'b0;
            PARALLEL_BRIDGE_EN <= 1'b0;
        end else begin
            BINARY_MODE <= bin_eff;
            LINE_VOL_EN <= (output_config_sel == pocr_pkg::OC_DIRECT)
                & ((line_output_sel == pocr_pkg::LN_VOL)
                | (line_output_sel == pocr_pkg::LN_VOL_EQ));
            LINE_EQ_EN <= (output_config_sel == pocr_pkg::OC_DIRECT)
                & (line_output_sel == pocr_pkg::LN_VOL_EQ);
            CH3_FULL_PROC <= (output_config_sel != pocr_pkg::OC_DIRECT);
            PARALLEL_BRIDGE_EN <= (output_config_sel == pocr_pkg::OC_MONO);
        end
    end

    pocr_fifo #(
        .WIDTH (FW),
        .DEPTH (pocr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (rst_n),
        .in_valid  (S_VALID),
        .in_ready  (S_READY),
        .in_data   (S_DATA),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data),
        .level     (f_level)
    );

    assign f_word = f_data;
    assign f_ready = !M_VALID | M_READY;
    assign pop = f_valid & f_ready;
    assign drop_word = invalid_input_mute_en
                     & (f_word.bad | (mute_state_reg == pocr_pkg::MS_MUTED));

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            mute_state_reg <= pocr_pkg::MS_PLAY;
            run_cnt_reg    <= 3'h0;
        end else if (!invalid_input_mute_en) begin
            mute_state_reg <= pocr_pkg::MS_PLAY;
            run_cnt_reg    <= 3'h0;
        end else if (pop) begin
            case (mute_state_reg)
                pocr_pkg::MS_PLAY: begin
                    if (f_word.bad) begin
                        mute_state_reg <= pocr_pkg::MS_MUTED;
                        run_cnt_reg    <= 3'h0;
                    end
                end
                pocr_pkg::MS_MUTED: begin
                    if (f_word.bad) begin
                        run_cnt_reg <= 3'h0;
                    end else if (run_cnt_reg
                                 == 3'(pocr_pkg::VALID_RUN - 1)) begin
                        mute_state_reg <= pocr_pkg::MS_PLAY;
                    end else begin
                        run_cnt_reg <= run_cnt_reg + 3'h1;
                    end
                end
                default: mute_state_reg <= pocr_pkg::MS_PLAY;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            M_VALID   <= 1'b0;
            M_DATA    <= '0;
            AUTO_MUTE <= 1'b0;
        end else begin
            if (pop) begin
                M_VALID <= 1'b1;
                M_DATA  <= drop_word ? '0 : f_word.pcm;
            end else if (M_READY) begin
                M_VALID <= 1'b0;
            end
            AUTO_MUTE <= (mute_state_reg == pocr_pkg::MS_MUTED);
        end
    end
endmodule

`default_nettype wire
